// ### hdl/adcsq_pkg.sv
// Purpose: shared constants for the a/d channel sequencer
// Assumes: 32-bit apb, each register one word at byte address 4 * index
// Notes: indices are the register numbers, not byte addresses
package adcsq_pkg;

    // ==========================================================
    // register indices (byte address is four times the index)
    // ==========================================================
    localparam logic [15:0] ADCSQ_IDX_RES0 = 16'hf820;
    localparam logic [15:0] ADCSQ_IDX_CTRL = 16'hf840;
    localparam logic [15:0] ADCSQ_IDX_RUN = 16'hf841;
    localparam logic [15:0] ADCSQ_IDX_EN = 16'hf842;
    localparam logic [15:0] ADCSQ_IDX_TCH = 16'hf844;
    localparam logic [15:0] ADCSQ_IDX_TRG = 16'hf846;
    localparam logic [15:0] ADCSQ_IDX_CVT = 16'hf848;
    localparam int ADCSQ_AW = 20;

    // ==========================================================
    // field positions
    // ==========================================================
    localparam int ADCSQ_CTRL_LOOP = 0;
    localparam int ADCSQ_CTRL_CK = 1;
    localparam int ADCSQ_CTRL_TCM = 2;
    localparam int ADCSQ_RUN_BIT = 0;
    localparam int ADCSQ_TRG_MODE = 0;
    localparam int ADCSQ_TRG_SRC_LSB = 8;
    localparam int ADCSQ_TRG_SRC_W = 5;
    localparam int ADCSQ_CVT_MID_LSB = 8;
    localparam int ADCSQ_CVT_HIGH_LSB = 11;
    localparam int ADCSQ_RES_W = 12;

    // ==========================================================
    // reset values and writable masks
    // ==========================================================
    localparam logic [15:0] ADCSQ_RST_CTRL = 16'h0002;
    localparam logic [15:0] ADCSQ_RST_EN = 16'h0000;
    localparam logic [15:0] ADCSQ_RST_TCH = 16'h0000;
    localparam logic [15:0] ADCSQ_RST_TRG = 16'h0000;
    localparam logic [15:0] ADCSQ_RST_CVT = 16'hffff;
    localparam logic [15:0] ADCSQ_MASK_CTRL = 16'h0007;
    localparam logic [15:0] ADCSQ_MASK_TRG = 16'h1f01;

    typedef enum logic [1:0] {
        SQ_IDLE,
        SQ_ISSUE,
        SQ_WAIT,
        SQ_STALL
    } adcsq_state_e;

endpackage : adcsq_pkg

// ### hdl/adcsq_trig_sel.sv
// Purpose: pick the trigger source and turn its rising edge into a pulse
// Assumes: request inputs are synchronous to core_clk, taken unmasked
// Notes: prohibited source codes never produce a pulse
`timescale 1ns/100ps
module adcsq_trig_sel
    import adcsq_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [4:0] src,
    input wire logic [7:0] timer_irq_requests,
    input wire logic [3:0] multitimer_trigger_outs,
    output logic trig_pulse
);
    logic src_valid;
    logic sel_level;
    logic sel_prev;

    // ==========================================================
    // source decode
    // ==========================================================
    always_comb begin
        src_valid = 1'b0;
        sel_level = 1'b0;
        if (src[4:3] == 2'b00) begin
            src_valid = 1'b1;
            sel_level = timer_irq_requests[src[2:0]];
        end else if (src[4:2] == 3'b100) begin
            src_valid = 1'b1;
            sel_level = multitimer_trigger_outs[src[1:0]];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sel_prev <= 1'b0;
        end else begin
            sel_prev <= sel_level;
        end
    end

    assign trig_pulse = src_valid & sel_level & ~sel_prev;

    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    property p_prohibited_quiet;
        (src[4:3] == 2'b01 || src[4:2] == 3'b101 || src[4:3] == 2'b11)
            |-> !trig_pulse;
    endproperty
    a_prohibited_quiet: assert property (p_prohibited_quiet)
        else $error("trigger from prohibited source code");

endmodule : adcsq_trig_sel

// ### hdl/adcsq_next_chan.sv
// Purpose: find the lowest-numbered channel still pending
// Assumes: mask bit n set means channel n waits for conversion
// Notes: purely combinational
`timescale 1ns/100ps
module adcsq_next_chan #(
    parameter int NCH = 12
) (
    input wire logic [NCH-1:0] mask,
    output logic found,
    output logic [3:0] index
);
    if (NCH < 1 || NCH > 16) begin : g_bad_nch
        $error("channel count out of range");
    end

    always_comb begin
        found = 1'b0;
        index = 4'h0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (mask[i]) begin
                found = 1'b1;
                index = 4'(i);
            end
        end
    end

endmodule : adcsq_next_chan

// ### hdl/adcsq_seq.sv
// Purpose: apb register file and channel sequencer of the a/d converter
// Assumes: conv_done is a one-cycle pulse from the core after conv_start
// Notes: zero-wait apb, read data captured in the setup cycle
`timescale 1ns/100ps
module adcsq_seq
    import adcsq_pkg::*;
#(
    parameter int NCH = 12
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADCSQ_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] timer_irq_requests,
    input wire logic [3:0] multitimer_trigger_outs,
    output logic conv_start,
    output logic [3:0] conv_channel,
    output logic conv_touch,
    output logic conv_clock_select,
    output logic [7:0] timing_field_low,
    output logic [2:0] timing_field_mid,
    output logic [4:0] timing_field_high,
    input wire logic conv_done,
    input wire logic [ADCSQ_RES_W-1:0] conv_result,
    output logic conversion_done_irq,
    output logic run_bit
);
    if (NCH < 1 || NCH > 16) begin : g_bad_nch
        $error("channel count out of range");
    end

    // ==========================================================
    // address decode
    // ==========================================================
    function automatic logic [16:0] adcsq_word_idx(
        input logic [ADCSQ_AW-1:0] a
    );
        adcsq_word_idx = {(a[1:0] == 2'b00) && (a[19:18] == 2'b00),
            a[17:2]};
    endfunction : adcsq_word_idx

    logic [16:0] acc_idx;
    logic wr;
    logic [15:0] ctrl_reg;
    logic [NCH-1:0] channel_enable;
    logic [NCH-1:0] touch_channel_select;
    logic [15:0] trigger_control;
    logic [15:0] conversion_timing;
    logic [ADCSQ_RES_W-1:0] result [NCH];
    logic err_q;
    logic [15:0] slot;

    assign acc_idx = adcsq_word_idx(paddr);
    assign slot = acc_idx[15:0] - ADCSQ_IDX_RES0;
    assign wr = psel & penable & pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & err_q;

    // ==========================================================
    // sequencer signals
    // ==========================================================
    adcsq_state_e state;
    logic [NCH-1:0] latched_mask;
    logic [NCH-1:0] rem;
    logic [NCH-1:0] eff_mask;
    logic touch_mode;
    logic loop_mode;
    logic trig_mode;
    logic touch_lat;
    logic trig_pulse;
    logic found;
    logic [3:0] next_idx;
    logic sw_run_wr;
    logic start;
    logic sw_stop;
    logic last_done;
    logic finish;

    assign touch_mode = ctrl_reg[ADCSQ_CTRL_TCM];
    assign loop_mode = ctrl_reg[ADCSQ_CTRL_LOOP];
    assign trig_mode = trigger_control[ADCSQ_TRG_MODE];
    assign conv_clock_select = ctrl_reg[ADCSQ_CTRL_CK];
    assign timing_field_low = conversion_timing[ADCSQ_CVT_MID_LSB-1:0];
    assign timing_field_mid =
        conversion_timing[ADCSQ_CVT_HIGH_LSB-1:ADCSQ_CVT_MID_LSB];
    assign timing_field_high = conversion_timing[15:ADCSQ_CVT_HIGH_LSB];

    // only matching enable, touch and global mode convert
    assign eff_mask = touch_mode ?
        (channel_enable & touch_channel_select) :
        (channel_enable & ~touch_channel_select);

    assign sw_run_wr = wr && acc_idx == {1'b1, ADCSQ_IDX_RUN}
        && !trig_mode;
    assign start = !run_bit && ((trig_mode && trig_pulse)
        || (sw_run_wr && pwdata[ADCSQ_RUN_BIT]));
    assign sw_stop = sw_run_wr && !pwdata[ADCSQ_RUN_BIT];
    assign last_done = state == SQ_WAIT && conv_done && rem == '0;
    // looping is never honoured in trigger mode
    assign finish = last_done && !(loop_mode && !trig_mode);

    adcsq_trig_sel u_trig (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .src(trigger_control[ADCSQ_TRG_SRC_LSB+:ADCSQ_TRG_SRC_W]),
        .timer_irq_requests(timer_irq_requests),
        .multitimer_trigger_outs(multitimer_trigger_outs),
        .trig_pulse(trig_pulse)
    );

    adcsq_next_chan #(
        .NCH(NCH)
    ) u_next (
        .mask(rem),
        .found(found),
        .index(next_idx)
    );

    // ==========================================================
    // register writes
    // ==========================================================
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctrl_reg <= ADCSQ_RST_CTRL;
            channel_enable <= ADCSQ_RST_EN[NCH-1:0];
            touch_channel_select <= ADCSQ_RST_TCH[NCH-1:0];
            trigger_control <= ADCSQ_RST_TRG;
            conversion_timing <= ADCSQ_RST_CVT;
        end else if (wr) begin
            case (acc_idx)
                {1'b1, ADCSQ_IDX_CTRL}: begin
                    ctrl_reg <= pwdata[15:0] & ADCSQ_MASK_CTRL;
                end
                {1'b1, ADCSQ_IDX_EN}: begin
                    channel_enable <= pwdata[NCH-1:0];
                end
                {1'b1, ADCSQ_IDX_TCH}: begin
                    touch_channel_select <= pwdata[NCH-1:0];
                end
                {1'b1, ADCSQ_IDX_TRG}: begin
                    trigger_control <= pwdata[15:0] & ADCSQ_MASK_TRG;
                end
                {1'b1, ADCSQ_IDX_CVT}: begin
                    conversion_timing <= pwdata[15:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // read data and error, captured in the setup cycle
    // ==========================================================
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
            err_q <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= 32'h0000_0000;
            err_q <= 1'b0;
            if (!acc_idx[16]) begin
                err_q <= 1'b1;
            end else if (acc_idx[15:0] == ADCSQ_IDX_CTRL) begin
                prdata[15:0] <= ctrl_reg;
            end else if (acc_idx[15:0] == ADCSQ_IDX_RUN) begin
                prdata[ADCSQ_RUN_BIT] <= run_bit;
            end else if (acc_idx[15:0] == ADCSQ_IDX_EN) begin
                prdata[NCH-1:0] <= channel_enable;
            end else if (acc_idx[15:0] == ADCSQ_IDX_TCH) begin
                prdata[NCH-1:0] <= touch_channel_select;
            end else if (acc_idx[15:0] == ADCSQ_IDX_TRG) begin
                prdata[15:0] <= trigger_control;
            end else if (acc_idx[15:0] == ADCSQ_IDX_CVT) begin
                prdata[15:0] <= conversion_timing;
            end else if (acc_idx[15:0] >= ADCSQ_IDX_RES0 && !slot[0]
                && slot[15:1] < 15'(NCH)) begin
                prdata[ADCSQ_RES_W-1:0] <= result[slot[4:1]];
            end else begin
                err_q <= 1'b1;
            end
        end
    end

    // ==========================================================
    // run bit
    // ==========================================================
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            run_bit <= 1'b0;
        end else if (start) begin
            run_bit <= 1'b1;
        end else if (finish || sw_stop) begin
            run_bit <= 1'b0;
        end
    end

    // ==========================================================
    // sequencer state machine
    // ==========================================================
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state <= SQ_IDLE;
            latched_mask <= '0;
            rem <= '0;
            touch_lat <= 1'b0;
        end else begin
            case (state)
                SQ_IDLE: begin
                    if (start) begin
                        latched_mask <= eff_mask;
                        rem <= eff_mask;
                        touch_lat <= touch_mode;
                        // empty selection parks with run still set
                        state <= (eff_mask != '0) ? SQ_ISSUE
                            : SQ_STALL;
                    end
                end
                SQ_ISSUE: begin
                    if (sw_stop || !found) begin
                        state <= SQ_IDLE;
                    end else begin
                        rem[next_idx] <= 1'b0;
                        state <= SQ_WAIT;
                    end
                end
                SQ_WAIT: begin
                    if (sw_stop) begin
                        state <= SQ_IDLE;
                    end else if (conv_done) begin
                        if (rem != '0) begin
                            state <= SQ_ISSUE;
                        end else if (finish) begin
                            state <= SQ_IDLE;
                        end else begin
                            rem <= latched_mask;
                            state <= SQ_ISSUE;
                        end
                    end
                end
                SQ_STALL: begin
                    if (sw_stop) begin
                        state <= SQ_IDLE;
                    end
                end
                default: begin
                    state <= SQ_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // converter core strobes and completion pulse
    // ==========================================================
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            conv_start <= 1'b0;
            conv_channel <= 4'h0;
            conv_touch <= 1'b0;
        end else begin
            conv_start <= state == SQ_ISSUE && found && !sw_stop;
            if (state == SQ_ISSUE && found) begin
                conv_channel <= next_idx;
                conv_touch <= touch_lat;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            conversion_done_irq <= 1'b0;
        end else begin
            conversion_done_irq <= last_done && !sw_stop;
        end
    end

    // ==========================================================
    // result store
    // ==========================================================
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < NCH; i++) begin
                result[i] <= '0;
            end
        end else if (state == SQ_WAIT && conv_done) begin
            result[conv_channel] <= conv_result;
        end
    end

    // ==========================================================
    // checks
    // ==========================================================
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    property p_empty_start;
        (state == SQ_IDLE && start && eff_mask == '0)
            |=> (state == SQ_STALL && run_bit) [*2];
    endproperty
    a_empty_start: assert property (p_empty_start)
        else $error("empty start did not park with run set");

    property p_stall_quiet;
        state == SQ_STALL |-> !conv_start && !conversion_done_irq;
    endproperty
    a_stall_quiet: assert property (p_stall_quiet)
        else $error("activity while parked on empty selection");

    property p_issue_order;
        (state == SQ_ISSUE && found && !sw_stop)
            |=> conv_start && conv_channel == $past(next_idx)
            && latched_mask[conv_channel];
    endproperty
    a_issue_order: assert property (p_issue_order)
        else $error("wrong channel issued");

    property p_trig_start;
        (trig_mode && trig_pulse && !run_bit && state == SQ_IDLE)
            |=> run_bit ##1 (state != SQ_IDLE || !run_bit);
    endproperty
    a_trig_start: assert property (p_trig_start)
        else $error("trigger did not start a sequence");

    property p_trig_ignored;
        (run_bit && trig_pulse && state != SQ_IDLE && !finish)
            |=> $stable(latched_mask) && run_bit;
    endproperty
    a_trig_ignored: assert property (p_trig_ignored)
        else $error("trigger disturbed running sequence");

    property p_sw_locked;
        (trig_mode && wr && acc_idx == {1'b1, ADCSQ_IDX_RUN}
            && !trig_pulse) |=> run_bit == $past(run_bit)
            || $past(finish);
    endproperty
    a_sw_locked: assert property (p_sw_locked)
        else $error("software changed run in trigger mode");

    property p_single_end;
        finish && !sw_stop |=> !run_bit && conversion_done_irq
            && state == SQ_IDLE;
    endproperty
    a_single_end: assert property (p_single_end)
        else $error("run not cleared after last channel");

    property p_result_store;
        (state == SQ_WAIT && conv_done)
            |=> result[$past(conv_channel)] == $past(conv_result);
    endproperty
    a_result_store: assert property (p_result_store)
        else $error("result not stored for its channel");

    property p_latch_hold;
        state != SQ_IDLE |=> $stable(latched_mask);
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("selection changed during sequence");

    property p_cvt_reset;
        $past(sys_rst) |-> conversion_timing == ADCSQ_RST_CVT;
    endproperty
    a_cvt_reset: assert property (p_cvt_reset)
        else $error("timing register reset value wrong");

    property p_res_width;
        (psel && !penable && acc_idx[15:0] < ADCSQ_IDX_CTRL)
            |=> prdata[31:ADCSQ_RES_W] == '0;
    endproperty
    a_res_width: assert property (p_res_width)
        else $error("result upper bits not zero");

endmodule : adcsq_seq

// ### verification/adcsq_core_model.sv
// Purpose: behavioural conversion core facing the sequencer
// Assumes: one conversion at a time, started by conv_start
// Notes: result encodes channel and touch flag; slow stretches time
`timescale 1ns/100ps
module adcsq_core_model (
    input wire logic core_clk,
    input wire logic slow,
    input wire logic conv_start,
    input wire logic [3:0] conv_channel,
    input wire logic conv_touch,
    output logic conv_done,
    output logic [11:0] conv_result
);
    int cnt = -1;
    initial begin
        conv_done = 1'b0;
        conv_result = 12'h000;
    end
    // ==========================================================
    // conversion timer
    // ==========================================================
    always @(posedge core_clk) begin
        conv_done <= 1'b0;
        // result bus is not valid outside the done cycle
        conv_result <= ~conv_result;
        if (conv_start) begin
            cnt <= slow ? 7 : 1;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end else if (cnt == 0) begin
            cnt <= -1;
            conv_done <= 1'b1;
            conv_result <= {conv_channel, 7'h2a, conv_touch};
        end
    end
endmodule : adcsq_core_model

// ### verification/adc_channel_sequencer_tb.sv
// Purpose: self-checking bench for the a/d channel sequencer
// Assumes: core model answers every conv_start
// Notes: expected order rebuilt from the selection masks
`timescale 1ns/100ps
module adc_channel_sequencer_tb
    import adcsq_pkg::*;
;
    logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, slow;
    logic [ADCSQ_AW-1:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [7:0] timer_irq_requests, t_low;
    logic [3:0] multitimer_trigger_outs, conv_channel;
    logic conv_start, conv_touch, conv_done, conversion_done_irq, run_bit;
    logic ck_sel;
    logic [11:0] conv_result;
    logic [2:0] t_mid;
    logic [4:0] t_high;
    logic [3:0] got_q[$];
    logic [15:0] lf;
    int bad_count, n_tests, irq_n;

    adcsq_seq DUT (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_irq_requests(timer_irq_requests),
        .multitimer_trigger_outs(multitimer_trigger_outs),
        .conv_start(conv_start), .conv_channel(conv_channel),
        .conv_touch(conv_touch), .conv_clock_select(ck_sel),
        .timing_field_low(t_low), .timing_field_mid(t_mid),
        .timing_field_high(t_high), .conv_done(conv_done),
        .conv_result(conv_result),
        .conversion_done_irq(conversion_done_irq), .run_bit(run_bit));
    adcsq_core_model core (.core_clk(core_clk), .slow(slow),
        .conv_start(conv_start), .conv_channel(conv_channel),
        .conv_touch(conv_touch), .conv_done(conv_done),
        .conv_result(conv_result));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (conv_start === 1'b1) begin
            got_q.push_back(conv_channel);
        end
        if (conversion_done_irq === 1'b1) begin
            irq_n++;
        end
    end

    // ==========================================================
    // checks and bus cycles
    // ==========================================================
    task automatic cmp(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : cmp

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    task automatic apb(input logic is_wr, input logic [15:0] idx,
                       input logic [31:0] wd, output logic err);
        int n;
        psel <= 1'b1;
        pwrite <= is_wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            bad_count++;
            end_of_test();
        end
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb

    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        logic e;
        apb(1'b1, idx, d, e);
    endtask : wr

    task automatic rd(input string what, input logic [15:0] idx,
                      input logic [31:0] exp);
        logic e;
        apb(1'b0, idx, 32'h0, e);
        cmp(what, exp, rdv);
    endtask : rd

    task automatic run_check(input logic [11:0] sel, input logic tch);
        int k;
        logic [3:0] got;
        for (k = 0; k < 3000 && irq_n == 0; k++) begin
            @(posedge core_clk);
        end
        if (irq_n == 0) begin
            bad_count++;
            end_of_test();
        end
        @(posedge core_clk);
        cmp("run", 0, run_bit);
        cmp("irqs", 1, irq_n);
        for (k = 0; k < 12; k++) begin
            if (sel[k]) begin
                got = got_q.size() ? got_q.pop_front() : 4'hf;
                cmp("order", k, got);
                rd("result", 16'(ADCSQ_IDX_RES0 + 2 * k),
                   {20'h0, k[3:0], 7'h2a, tch});
            end
        end
        cmp("extra", 0, got_q.size());
        irq_n = 0;
    endtask : run_check

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin : main
        logic e;
        logic [11:0] en, tch, sel, tv;
        logic [4:0] code;
        int i;
        sys_rst = 1'b1;
        {psel, penable, pwrite, slow} = 4'h0;
        paddr = '0;
        pwdata = 32'h0;
        {multitimer_trigger_outs, timer_irq_requests} = 12'h000;
        {bad_count, n_tests, irq_n} = '0;
        lf = 16'h0008;
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        cmp("clock select", 1, ck_sel);
        rd("ctrl", ADCSQ_IDX_CTRL, 32'h0000_0002);
        rd("run", ADCSQ_IDX_RUN, 0);
        rd("enable", ADCSQ_IDX_EN, 0);
        rd("touch", ADCSQ_IDX_TCH, 0);
        rd("trigger", ADCSQ_IDX_TRG, 0);
        rd("timing", ADCSQ_IDX_CVT, 32'h0000_ffff);
        apb(1'b0, 16'h0001, 32'h0, e);
        cmp("unmapped", 1, e);
        wr(ADCSQ_IDX_CVT, 32'h0000_ab78);
        cmp("fields", 32'h0000_ab78, {16'h0, t_high, t_mid, t_low});
        $display("test registers done");
        for (i = 0; i < 4; i++) begin
            lf = lfsr(lf);
            en = lf[11:0] | 12'h001;
            lf = lfsr(lf);
            tch = lf[11:0];
            sel = en & (i[0] ? tch : ~tch);
            if (sel == 12'h000) begin
                tch = i[0] ? en : 12'h000;
                sel = en;
            end
            slow <= i[1];
            wr(ADCSQ_IDX_CTRL, {29'h0, i[0], 2'b10});
            wr(ADCSQ_IDX_EN, {20'h0, en});
            wr(ADCSQ_IDX_TCH, {20'h0, tch});
            got_q.delete();
            wr(ADCSQ_IDX_RUN, 1);
            wr(ADCSQ_IDX_EN, 0);
            run_check(sel, i[0]);
        end
        $display("test software start done");
        wr(ADCSQ_IDX_CTRL, 32'h0000_0002);
        wr(ADCSQ_IDX_EN, 32'h0000_0005);
        wr(ADCSQ_IDX_TCH, 32'h0000_0005);
        wr(ADCSQ_IDX_RUN, 1);
        repeat (40) @(posedge core_clk);
        cmp("empty", 0, got_q.size() + irq_n);
        rd("empty run", ADCSQ_IDX_RUN, 1);
        wr(ADCSQ_IDX_RUN, 0);
        $display("test empty start done");
        wr(ADCSQ_IDX_TCH, 0);
        wr(ADCSQ_IDX_EN, 32'h0000_0010);
        slow <= 1'b1;
        wr(ADCSQ_IDX_CTRL, 32'h0000_0003);
        got_q.delete();
        wr(ADCSQ_IDX_RUN, 1);
        for (i = 0; i < 400 && irq_n < 2; i++) begin
            @(posedge core_clk);
        end
        cmp("loop run", 1, run_bit);
        cmp("loop irqs", 1, irq_n > 1);
        wr(ADCSQ_IDX_RUN, 0);
        cmp("loop stop", 0, run_bit);
        cmp("loop chan", 4, got_q.pop_front());
        // let the aborted conversion drain before the next start
        repeat (16) @(posedge core_clk);
        irq_n = 0;
        $display("test loop done");
        // looping stays set below: trigger mode must ignore it
        for (i = 0; i < 16; i++) begin
            code = 5'((i < 8) ? i : (i < 12) ? i + 8 : (i - 12) * 7 + 8);
            tv = (i < 12) ? 12'h001 << i : 12'hfff;
            wr(ADCSQ_IDX_TRG, {19'h0, code, 8'h01});
            got_q.delete();
            wr(ADCSQ_IDX_RUN, 1);
            cmp("sw run", 0, run_bit);
            {multitimer_trigger_outs, timer_irq_requests} <= tv;
            @(posedge core_clk);
            {multitimer_trigger_outs, timer_irq_requests} <= 12'h000;
            repeat (3) @(posedge core_clk);
            cmp("trig run", i < 12, run_bit);
            {multitimer_trigger_outs, timer_irq_requests} <= tv;
            @(posedge core_clk);
            {multitimer_trigger_outs, timer_irq_requests} <= 12'h000;
            if (i < 12) begin
                run_check(12'h010, 1'b0);
            end else begin
                cmp("trig none", 0, got_q.size() + irq_n);
            end
        end
        $display("test trigger done");
        end_of_test();
    end
endmodule : adc_channel_sequencer_tb
